// ==== rtl/pcc_consts.svh ====
// register offsets, field positions, reset values and timing for the pixel clock controller
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_CTRL_OFS 12'h000
`define PCC_STAT_OFS 12'h004
`define PCC_LADDR_OFS 12'h008
`define PCC_LDATA_OFS 12'h00c
`define PCC_F_MUX 1:0
`define PCC_F_PDIV 3:2
`define PCC_F_VCAL 4
`define PCC_F_FMT 8:5
`define PCC_F_GAMMA 9
`define PCC_F_ARM 10
`define PCC_F_EXEC 11
`define PCC_CTRL_W 12
`define PCC_CTRL_RST 12'h000
`define PCC_REF_RST 2'h0
`define PCC_DLY_N 5
`endif

// ==== rtl/pcc_pkg.sv ====
// types shared by the pixel clock controller
package pcc_pkg;
  typedef enum logic [1:0] {PCC_PSEUDO, PCC_TRUE15, PCC_TRUE24} pcc_cmode_type;
  typedef enum logic {PCC_CAL_IDLE, PCC_CAL_SEEK} pcc_cal_type;
endpackage

// ==== rtl/pcc_divider.sv ====
// pixel clock divider for load strobe and programmable subsystem clock
`timescale 1ns/1ps
module pcc_divider #(
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // division selects, as log2 of the ratio
  input wire logic [1:0] ldiv_log,
  input wire logic [2:0] pdiv_log,
  // divided outputs
  output logic load_q,
  output logic prog_q,
  output logic [CNT_W-1:0] cnt_q
);
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] lmask;
  logic load_d;
  logic prog_d;

  // both outputs decode one counter, so prog rises only where load pulses
  always_comb
  begin
    cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    lmask = CNT_W'((32'h1 << ldiv_log) - 32'h1);
    load_d = (cnt_d & lmask) == '0;
    // prog may only rise with a load pulse, even while a ratio changes
    prog_d = ~cnt_d[3'(pdiv_log - 3'h1)] & (prog_q | load_d);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      load_q <= 1'b0;
      prog_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      load_q <= load_d;
      prog_q <= prog_d;
    end
  end
endmodule // pcc_divider

// ==== rtl/pcc_lut.sv ====
// look-up table in flip-flops, one write port and three registered read ports
`timescale 1ns/1ps
module pcc_lut #(
  parameter int AW = 8,
  parameter int DW = 30
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read ports, one per converter
  input wire logic [AW-1:0] ra0,
  input wire logic [AW-1:0] ra1,
  input wire logic [AW-1:0] ra2,
  output logic [DW-1:0] rd0,
  output logic [DW-1:0] rd1,
  output logic [DW-1:0] rd2
);
  logic [DW-1:0] mem_q [2**AW];

  // table storage, loaded by software
  always_ff @(posedge clock)
  begin
    if (we)
      mem_q[waddr] <= wdata;
  end

  // registered reads
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd0 <= '0;
      rd1 <= '0;
      rd2 <= '0;
    end
    else
    begin
      rd0 <= mem_q[ra0];
      rd1 <= mem_q[ra1];
      rd2 <= mem_q[ra2];
    end
  end
endmodule // pcc_lut

// ==== rtl/pcc_pixel_clock_ctrl.sv ====
// pixel clock control and color mode logic with apb registers
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_pixel_clock_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pixel port
  input wire logic pixel_latch_in,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic sync_n_in,
  input wire logic blank_n_in,
  input wire logic [1:0] palette_sel_in,
  input wire logic vsync_n_in,
  // clocks to the system
  input wire logic shift_clk_in,
  output logic load_strobe_out,
  output logic prog_subsys_clk_out,
  output logic shift_clk_out,
  // converter data
  output logic [9:0] dac_r,
  output logic [9:0] dac_g,
  output logic [9:0] dac_b,
  output logic dac_sync_n,
  output logic dac_blank_n,
  output logic [1:0] palette_sel_out
);
  logic [`PCC_CTRL_W-1:0] ctrl_q;
  logic [7:0] laddr_q;
  logic [4:0] cnt;
  logic [1:0] ldiv_log;
  logic [2:0] pdiv_log;
  logic [1:0] phase_now;
  logic latch_prev_q, latch_ev;
  logic [7:0] cap_r_q, cap_g_q, cap_b_q;
  logic cap_sync_n_q, cap_blank_n_q;
  logic [1:0] cap_ps_q;
  logic [3:0] ctl1_q;
  logic [7:0] ra, ga, ba;
  logic [29:0] rd0, rd1, rd2;
  logic [33:0] fmt_d;
  logic [33:0] dly_q [`PCC_DLY_N];
  logic [2:0] extra_lat;
  pcc_pkg::pcc_cmode_type cmode;
  pcc_pkg::pcc_cal_type cal_q;
  logic [1:0] ref_q;
  logic miss_q, calibrated_q, cal_req_q, arm_seen_q, vsync_prev_q;
  logic access, commit, hit, wr_ctrl, wr_ldata, cal_trig, vsync_fall;
  logic [31:0] rdata_d;

  // apb decode; one wait state, write lands at the pready edge
  always_comb
  begin
    access = psel & penable & ~pready;
    hit = (paddr == `PCC_CTRL_OFS) | (paddr == `PCC_STAT_OFS) |
          (paddr == `PCC_LADDR_OFS) | (paddr == `PCC_LDATA_OFS);
    commit = psel & penable & pready & pwrite & hit;
    wr_ctrl = commit & (paddr == `PCC_CTRL_OFS);
    wr_ldata = commit & (paddr == `PCC_LDATA_OFS);
    rdata_d = 32'h0;
    case (paddr)
      `PCC_CTRL_OFS: rdata_d = {20'h0, ctrl_q};
      `PCC_STAT_OFS: rdata_d = {24'h0, ref_q, extra_lat, miss_q, cal_q == pcc_pkg::PCC_CAL_SEEK, calibrated_q};
      `PCC_LADDR_OFS: rdata_d = {24'h0, laddr_q};
      default: rdata_d = 32'h0;
    endcase
  end

  // apb answer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access;
      pslverr <= access & ~hit;
      if (access)
        prdata <= pwrite ? 32'h0 : rdata_d;
    end
  end

  // control register and table address pointer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `PCC_CTRL_RST;
      laddr_q <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[`PCC_CTRL_W-1:0];
      if (commit & (paddr == `PCC_LADDR_OFS))
        laddr_q <= pwdata[7:0];
      else if (wr_ldata)
        laddr_q <= laddr_q + 8'h01; // wraps to zero after the last entry
    end
  end

  // ratio selects: mux field 0 is 1:1, 1 is 2:1, else 4:1
  always_comb
  begin
    ldiv_log = (ctrl_q[`PCC_F_MUX] == 2'h0) ? 2'h0 : (ctrl_q[`PCC_F_MUX] == 2'h1) ? 2'h1 : 2'h2;
    pdiv_log = 3'h2 + {1'b0, ctrl_q[`PCC_F_PDIV]};
    phase_now = cnt[1:0] & 2'((3'h1 << ldiv_log) - 3'h1);
  end

  pcc_divider #(.CNT_W(5)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .ldiv_log(ldiv_log),
    .pdiv_log(pdiv_log),
    .load_q(load_strobe_out),
    .prog_q(prog_subsys_clk_out),
    .cnt_q(cnt)
  );

  // latch strobe edge; in 1:1 every high cycle is a load
  always_comb
  begin
    latch_ev = pixel_latch_in & (~latch_prev_q | (ldiv_log == 2'h0));
    vsync_fall = vsync_prev_q & ~vsync_n_in;
  end

  // pixel capture on the returned strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_prev_q <= 1'b0;
      cap_r_q <= 8'h00;
      cap_g_q <= 8'h00;
      cap_b_q <= 8'h00;
      cap_sync_n_q <= 1'b1;
      cap_blank_n_q <= 1'b0;
      cap_ps_q <= 2'h0;
    end
    else
    begin
      latch_prev_q <= pixel_latch_in;
      if (latch_ev)
      begin
        cap_r_q <= red_in;
        cap_g_q <= green_in;
        cap_b_q <= blue_in;
        cap_sync_n_q <= sync_n_in;
        cap_blank_n_q <= blank_n_in;
        cap_ps_q <= palette_sel_in;
      end
    end
  end

  // shift clock held off while blanked
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shift_clk_out <= 1'b0;
    else
      shift_clk_out <= shift_clk_in & cap_blank_n_q;
  end

  // calibration requests: arm toggle then execute toggle, or vertical sync
  always_comb
  begin
    cal_trig = wr_ctrl & arm_seen_q & (pwdata[`PCC_F_EXEC] != ctrl_q[`PCC_F_EXEC]);
    cal_trig = cal_trig | (vsync_fall & ctrl_q[`PCC_F_VCAL]);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arm_seen_q <= 1'b0;
      cal_req_q <= 1'b0;
      vsync_prev_q <= 1'b1;
    end
    else
    begin
      vsync_prev_q <= vsync_n_in;
      if (wr_ctrl & (pwdata[`PCC_F_ARM] != ctrl_q[`PCC_F_ARM]))
        arm_seen_q <= 1'b1;
      else if (cal_trig)
        arm_seen_q <= 1'b0;
      // a new request wins over the clear
      if (cal_trig)
        cal_req_q <= 1'b1;
      else if (cal_q == pcc_pkg::PCC_CAL_IDLE)
        cal_req_q <= 1'b0;
    end
  end

  // calibration adopts the observed latch phase as the reference window
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_q <= pcc_pkg::PCC_CAL_IDLE;
      ref_q <= `PCC_REF_RST;
      miss_q <= 1'b0;
      calibrated_q <= 1'b0;
    end
    else
    begin
      case (cal_q)
        pcc_pkg::PCC_CAL_IDLE:
        begin
          if (cal_req_q)
            cal_q <= pcc_pkg::PCC_CAL_SEEK;
          if (latch_ev)
            miss_q <= phase_now != ref_q;
        end
        pcc_pkg::PCC_CAL_SEEK:
        begin
          if (latch_ev)
          begin
            ref_q <= phase_now;
            miss_q <= 1'b0;
            calibrated_q <= 1'b1;
            cal_q <= pcc_pkg::PCC_CAL_IDLE;
          end
        end
        default: cal_q <= pcc_pkg::PCC_CAL_IDLE;
      endcase
    end
  end

  // color mode decode and table addressing
  always_comb
  begin
    if (ctrl_q[8] & ctrl_q[7])
      cmode = ctrl_q[6] ? pcc_pkg::PCC_TRUE24 : pcc_pkg::PCC_TRUE15;
    else
      cmode = pcc_pkg::PCC_PSEUDO;
    extra_lat = miss_q ? 3'((3'h1 << ldiv_log) & 3'h6) : 3'h0;
    case (cmode)
      pcc_pkg::PCC_TRUE24:
      begin
        ra = cap_r_q;
        ga = cap_g_q;
        ba = cap_b_q;
      end
      pcc_pkg::PCC_TRUE15:
      begin
        ra = {3'h0, cap_r_q[7:3]};
        ga = {3'h0, cap_g_q[7:3]};
        ba = {3'h0, cap_b_q[7:3]};
      end
      default:
      begin
        ra = cap_r_q;
        ga = cap_r_q;
        ba = cap_r_q;
      end
    endcase
  end

  pcc_lut #(.AW(8), .DW(30)) u_lut (
    .clock(clock),
    .rst_n(rst_n),
    .we(wr_ldata),
    .waddr(laddr_q),
    .wdata(pwdata[29:0]),
    .ra0(ra),
    .ra1(ga),
    .ra2(ba),
    .rd0(rd0),
    .rd1(rd1),
    .rd2(rd2)
  );

  // converter word: 10-bit fields, or 8-bit values shifted up
  always_comb
  begin
    if (ctrl_q[`PCC_F_GAMMA])
      fmt_d = {ctl1_q, rd0[29:20], rd1[19:10], rd2[9:0]};
    else
      fmt_d = {ctl1_q, rd0[27:20], 2'h0, rd1[17:10], 2'h0, rd2[7:0], 2'h0};
  end

  // control bits follow the table read, then a delay line adds slip latency
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl1_q <= 4'h8; // sync idle high, blank asserted
      for (int i = 0; i < `PCC_DLY_N; i++)
        dly_q[i] <= 34'h200000000;
    end
    else
    begin
      ctl1_q <= {cap_sync_n_q, cap_blank_n_q, cap_ps_q};
      dly_q[0] <= fmt_d;
      for (int i = 1; i < `PCC_DLY_N; i++)
        dly_q[i] <= dly_q[i-1];
    end
  end

  // output registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {dac_sync_n, dac_blank_n, palette_sel_out} <= 4'h8;
      dac_r <= 10'h000;
      dac_g <= 10'h000;
      dac_b <= 10'h000;
    end
    else
    begin
      {dac_sync_n, dac_blank_n, palette_sel_out} <= dly_q[extra_lat][33:30];
      dac_r <= dly_q[extra_lat][29:20];
      dac_g <= dly_q[extra_lat][19:10];
      dac_b <= dly_q[extra_lat][9:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_load4;
    (load_strobe_out && ldiv_log == 2'h2 && $past(ldiv_log) == 2'h2) ##1 (ldiv_log == 2'h2) [*3] |=> load_strobe_out;
  endproperty
  a_load4: assert property (p_load4) else $error("load strobe not at clock over 4");

  property p_load_gap;
    (load_strobe_out && ldiv_log == 2'h1 && $past(ldiv_log) == 2'h1) ##1 (ldiv_log == 2'h1) |-> !load_strobe_out;
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("load strobe too frequent in 2:1");

  property p_prog4;
    ($rose(prog_subsys_clk_out) && pdiv_log == 3'h2 && $past(pdiv_log) == 3'h2 && ldiv_log == 2'h2) ##1
      (pdiv_log == 3'h2 && ldiv_log == 2'h2) [*3] |=> $rose(prog_subsys_clk_out);
  endproperty
  a_prog4: assert property (p_prog4) else $error("subsystem clock period wrong");

  property p_prog_on_load;
    $rose(prog_subsys_clk_out) |-> load_strobe_out;
  endproperty
  a_prog_on_load: assert property (p_prog_on_load) else $error("subsystem clock rose off load edge");

  property p_shift_off;
    !cap_blank_n_q |=> !shift_clk_out;
  endproperty
  a_shift_off: assert property (p_shift_off) else $error("shift clock ran during blanking");

  property p_capture;
    latch_ev |=> (cap_r_q == $past(red_in)) && (cap_blank_n_q == $past(blank_n_in));
  endproperty
  a_capture: assert property (p_capture) else $error("pixel not captured on latch edge");

  property p_extra4;
    (miss_q && ldiv_log == 2'h2) |-> extra_lat == 3'h4;
  endproperty
  a_extra4: assert property (p_extra4) else $error("missed window latency not 4");

  property p_extra1to1;
    (ldiv_log == 2'h0) |-> extra_lat == 3'h0;
  endproperty
  a_extra1to1: assert property (p_extra1to1) else $error("1:1 mode got extra latency");

  property p_cal_align;
    (cal_q == pcc_pkg::PCC_CAL_SEEK && latch_ev) |=> ref_q == $past(phase_now) && !miss_q && calibrated_q;
  endproperty
  a_cal_align: assert property (p_cal_align) else $error("calibration did not align");

  property p_cal_start;
    cal_trig |-> ##[1:2] cal_q == pcc_pkg::PCC_CAL_SEEK;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_pseudo_idx;
    cmode == pcc_pkg::PCC_PSEUDO |-> ga == cap_r_q && ba == cap_r_q;
  endproperty
  a_pseudo_idx: assert property (p_pseudo_idx) else $error("pseudo index not shared");

  property p_true15_addr;
    cmode == pcc_pkg::PCC_TRUE15 |-> ra[7:5] == 3'h0 && ga[4:0] == cap_g_q[7:3];
  endproperty
  a_true15_addr: assert property (p_true15_addr) else $error("15-bit address not in low bits");

  property p_std_low0;
    !ctrl_q[`PCC_F_GAMMA] |=> dly_q[0][1:0] == 2'h0 && dly_q[0][21:20] == 2'h0;
  endproperty
  a_std_low0: assert property (p_std_low0) else $error("low converter bits not zero");

  property p_true24_addr;
    cmode == pcc_pkg::PCC_TRUE24 |-> ra == cap_r_q && ga == cap_g_q && ba == cap_b_q;
  endproperty
  a_true24_addr: assert property (p_true24_addr) else $error("24-bit address mismatch");

  c_cal: cover property (cal_q == pcc_pkg::PCC_CAL_SEEK ##[1:20] calibrated_q);
  c_miss: cover property (miss_q && ldiv_log == 2'h2);
  c_prog32: cover property ($rose(prog_subsys_clk_out) && pdiv_log == 3'h5);
endmodule // pcc_pixel_clock_ctrl

// ==== verif/pcc_fb_model.sv ====
// frame buffer side model that returns the load strobe to the latch input
`timescale 1ns/1ps
module pcc_fb_model (
  // clock
  input wire logic clock,
  // strobe loop
  input wire logic load_strobe_out,
  input wire logic [1:0] ret_dly,
  output logic pixel_latch_in
);
  logic [2:0] dly_q;
  // delay line standing in for shift clock buffering
  always_ff @(posedge clock)
  begin
    dly_q <= {dly_q[1:0], load_strobe_out};
  end
  // direct tie, or return delayed by ret_dly clocks
  assign pixel_latch_in = (ret_dly == 2'h0) ? load_strobe_out : dly_q[ret_dly - 2'h1];
endmodule // pcc_fb_model

// ==== verif/pcc_pixel_clock_ctrl_tb_top.sv ====
// self-checking bench for the pixel clock controller
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_pixel_clock_ctrl_tb_top;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, prev, pixel_latch_in;
  logic sync_n_in, blank_n_in, vsync_n_in, shift_clk_in, load_strobe_out, prog_subsys_clk_out;
  logic shift_clk_out, dac_sync_n, dac_blank_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cur;
  logic [7:0] red_in, green_in, blue_in, ar, ag, ab;
  logic [1:0] palette_sel_in, palette_sel_out, ret_dly;
  logic [9:0] dac_r, dac_g, dac_b, er, eg, eb;
  logic [29:0] xr, xg, xb;
  logic [3:0] fm [10] = '{4'he, 4'he, 4'h0, 4'h2, 4'h4, 4'h0, 4'h2, 4'h4, 4'hc, 4'hd};
  logic gm [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int n_errors, compares, cnt, i, k, m;

  // pixel clock, 4 ns
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  pcc_pixel_clock_ctrl u_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_latch_in(pixel_latch_in), .red_in(red_in), .green_in(green_in), .blue_in(blue_in),
    .sync_n_in(sync_n_in), .blank_n_in(blank_n_in), .palette_sel_in(palette_sel_in), .vsync_n_in(vsync_n_in),
    .shift_clk_in(shift_clk_in), .load_strobe_out(load_strobe_out), .prog_subsys_clk_out(prog_subsys_clk_out),
    .shift_clk_out(shift_clk_out), .dac_r(dac_r), .dac_g(dac_g), .dac_b(dac_b), .dac_sync_n(dac_sync_n),
    .dac_blank_n(dac_blank_n), .palette_sel_out(palette_sel_out));

  pcc_fb_model u_fb (.clock(clock), .load_strobe_out(load_strobe_out), .ret_dly(ret_dly),
    .pixel_latch_in(pixel_latch_in));

  // counts and final verdict
  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int j;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (j = 0; j < 20; j++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (j == 20)
    begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // control word from fields
  function automatic logic [31:0] mk(input logic [1:0] mr, input logic [1:0] pd, input logic [3:0] f,
    input logic g);
    logic [31:0] v;
    v = 32'h0;
    v[`PCC_F_MUX] = mr;
    v[`PCC_F_PDIV] = pd;
    v[`PCC_F_FMT] = f;
    v[`PCC_F_GAMMA] = g;
    return v;
  endfunction

  // table word with distinct fields per converter
  function automatic logic [29:0] lw(input logic [7:0] a);
    return {a[1:0] ^ 2'h3, a, a[3:2], ~a, a[5:4], a ^ 8'h5a};
  endfunction

  // run-length guard
  initial
  begin
    repeat (60000) @(posedge clock);
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {red_in, green_in, blue_in, palette_sel_in, shift_clk_in, ret_dly} = '0;
    {sync_n_in, blank_n_in, vsync_n_in} = 3'h7;
    repeat (20) @(posedge clock);
    check({dac_sync_n, dac_blank_n, shift_clk_out, pready}, 32'h8);
    rst_n <= 1'b1;
    apb(1'b1, `PCC_CTRL_OFS, 32'h0000_0a5c);
    apb(1'b0, `PCC_CTRL_OFS, 32'h0);
    check(rd, 32'h0000_0a5c);
    apb(1'b0, 12'h010, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    $display("test apb done");
    // strobe rate per mux setting
    for (m = 0; m < 4; m++)
    begin
      apb(1'b1, `PCC_CTRL_OFS, mk(m[1:0], 2'h0, 4'h0, 1'b0));
      repeat (8) @(negedge clock);
      cnt = 0;
      repeat (32) @(negedge clock) cnt += int'(load_strobe_out === 1'b1);
      check(cnt, 32 >> ((m == 3) ? 2 : m));
    end
    $display("test strobe done");
    // subsystem clock rate and alignment with the strobe
    for (m = 0; m < 4; m++)
    begin
      apb(1'b1, `PCC_CTRL_OFS, mk(2'h2, m[1:0], 4'h0, 1'b0));
      repeat (40) @(negedge clock);
      prev = prog_subsys_clk_out;
      cnt = 0;
      for (i = 0; i < 64; i++)
      begin
        @(negedge clock);
        if (prev === 1'b0 && prog_subsys_clk_out === 1'b1)
        begin
          cnt++;
          check(load_strobe_out, 1'b1);
        end
        prev = prog_subsys_clk_out;
      end
      check(cnt, 64 >> (m + 2));
    end
    $display("test subsystem clock done");
    // shift clock gated by blanking
    apb(1'b1, `PCC_CTRL_OFS, mk(2'h0, 2'h0, 4'h0, 1'b0));
    for (m = 1; m >= 0; m--)
    begin
      blank_n_in <= m[0];
      repeat (8) @(posedge clock);
      @(negedge clock) prev = shift_clk_in;
      for (i = 0; i < 16; i++)
      begin
        @(posedge clock) shift_clk_in <= (i % 3 == 0);
        @(negedge clock) check(shift_clk_out, prev & m[0]);
        prev = shift_clk_in;
      end
    end
    blank_n_in <= 1'b1;
    $display("test shift clock done");
    // table load and every color mode
    apb(1'b1, `PCC_LADDR_OFS, 32'h0);
    for (i = 0; i < 256; i++)
      apb(1'b1, `PCC_LDATA_OFS, {2'h0, lw(i[7:0])});
    for (k = 0; k < 10; k++)
    begin
      apb(1'b1, `PCC_CTRL_OFS, mk(2'h0, 2'h0, fm[k], gm[k]));
      red_in <= 8'hc6 + 8'(k * 37);
      green_in <= 8'h3a + 8'(k * 11);
      blue_in <= 8'h71 - 8'(k * 5);
      sync_n_in <= k[0];
      palette_sel_in <= k[1:0];
      repeat (10) @(posedge clock);
      @(negedge clock);
      {ar, ag, ab} = {red_in, red_in, red_in};
      if (fm[k][3:1] == 3'b111)
        {ar, ag, ab} = {red_in, green_in, blue_in};
      if (fm[k][3:1] == 3'b110)
        {ar, ag, ab} = {3'h0, red_in[7:3], 3'h0, green_in[7:3], 3'h0, blue_in[7:3]};
      {xr, xg, xb} = {lw(ar), lw(ag), lw(ab)};
      er = gm[k] ? xr[29:20] : {xr[27:20], 2'h0};
      eg = gm[k] ? xg[19:10] : {xg[17:10], 2'h0};
      eb = gm[k] ? xb[9:0] : {xb[7:0], 2'h0};
      check({2'h0, dac_r, dac_g, dac_b}, {2'h0, er, eg, eb});
      check({dac_sync_n, dac_blank_n, palette_sel_out}, {sync_n_in, 1'b1, palette_sel_in});
    end
    $display("test color modes done");
    // late strobe return, then calibration by mode bits and by vertical sync
    ret_dly <= 2'h1;
    for (m = 0; m < 3; m++)
    begin
      cur = mk(m[1:0], 2'h0, 4'h0, 1'b0);
      apb(1'b1, `PCC_CTRL_OFS, cur);
      repeat (16) @(posedge clock);
      apb(1'b0, `PCC_STAT_OFS, 32'h0);
      check({rd[2], rd[5:3]}, {m != 0, 3'(m * 2)});
    end
    cur[`PCC_F_ARM] = 1'b1;
    apb(1'b1, `PCC_CTRL_OFS, cur);
    cur[`PCC_F_EXEC] = 1'b1;
    apb(1'b1, `PCC_CTRL_OFS, cur);
    for (i = 0; i < 50; i++)
    begin
      apb(1'b0, `PCC_STAT_OFS, 32'h0);
      if (rd[1:0] === 2'h1)
        break;
    end
    check({rd[2], rd[1:0]}, 3'h1);
    ret_dly <= 2'h2;
    repeat (16) @(posedge clock);
    apb(1'b0, `PCC_STAT_OFS, 32'h0);
    check(rd[2], 1'b1);
    cur[`PCC_F_VCAL] = 1'b1;
    apb(1'b1, `PCC_CTRL_OFS, cur);
    vsync_n_in <= 1'b0;
    repeat (4) @(posedge clock);
    vsync_n_in <= 1'b1;
    repeat (24) @(posedge clock);
    apb(1'b0, `PCC_STAT_OFS, 32'h0);
    check({rd[2], rd[0]}, 2'h1);
    $display("test calibration done");
    print_verdict();
  end
endmodule // pcc_pixel_clock_ctrl_tb_top
